// ---- include/amc_pkg.sv ----
/*
  Shared constants, types and ratio functions for the audio master clock
  selection block and the audio processor that faces it.
  Assumes a single 100 MHz system clock on both ends.
*/
`default_nettype none
package amc_pkg;
  localparam logic [7:0] AMC_ADDR_MODE = 8'h03;
  localparam logic [7:0] AMC_ADDR_CLK = 8'h06;
  localparam logic [7:0] AMC_ADDR_STAT = 8'h07;
  localparam logic [7:0] AMC_MODE_RST = 8'h00;
  localparam logic [7:0] AMC_CLK_RST = 8'h00;
  localparam int AMC_CLK_SEL_LSB = 0;
  localparam int AMC_CLK_REF_BIT = 2;
  localparam int AMC_CLK_FORCE_BIT = 3;
  localparam int AMC_MODE_SPEED_LSB = 0;
  localparam int AMC_MODE_ONE_LINE = 2;
  localparam int AMC_MODE_CX_MASTER = 3;
  localparam int AMC_MODE_SAI_MASTER = 4;
  localparam logic [7:0] AMC_HOST_ADDR_CTRL = 8'h10;
  localparam logic [7:0] AMC_HOST_ADDR_CTRL2 = 8'h11;
  localparam logic [7:0] AMC_HOST_FWD_LIMIT = 8'h10;
  localparam logic [7:0] AMC_HOST_CTRL_RST = 8'h00;
  localparam int AMC_PIN_CXF = 0;
  localparam int AMC_PIN_CXB = 1;
  localparam int AMC_PIN_SAF = 2;
  localparam int AMC_PIN_SAB = 3;
  localparam int AMC_SYNC_EXT = 4;
  localparam int AMC_SYNC_RX = 5;
  localparam int AMC_REF_CLK_MHZ = 100;
  localparam int AMC_REF_CLK_KHZ = AMC_REF_CLK_MHZ * 1000;
  localparam int AMC_FS_DS_MIN_KHZ = 50;
  localparam int AMC_FS_QS_MIN_KHZ = 100;
  localparam int AMC_P_DS_MAX = AMC_REF_CLK_KHZ / AMC_FS_DS_MIN_KHZ;
  localparam int AMC_P_QS_MAX = AMC_REF_CLK_KHZ / AMC_FS_QS_MIN_KHZ;
  localparam int AMC_LOCK_TIMEOUT_US = 250;
  localparam int AMC_LOCK_TIMEOUT_CYC = AMC_LOCK_TIMEOUT_US * AMC_REF_CLK_MHZ;
  localparam int AMC_PW = 17;
  localparam logic [16:0] AMC_PLL_STEP = 17'h0_0200;
  localparam logic [16:0] AMC_LOCK_TOL = 17'h0_0004;
  localparam logic [2:0] AMC_LOCK_HITS = 3'h4;
  localparam int AMC_HOST_MCLK_HALF = 4;

  typedef enum logic [1:0] {
    AMC_SPEED_SINGLE = 2'b00,
    AMC_SPEED_DOUBLE = 2'b01,
    AMC_SPEED_QUAD = 2'b10,
    AMC_SPEED_RSVD = 2'b11
  } amc_speed_t;

  typedef enum logic [1:0] {
    AMC_SEL_PLL = 2'b00,
    AMC_SEL_EXT = 2'b01,
    AMC_SEL_AUTO = 2'b10,
    AMC_SEL_AUTO2 = 2'b11
  } amc_sel_t;

  function automatic logic [7:0] amc_os_ratio(input logic [1:0] sp);
    amc_os_ratio = (sp == AMC_SPEED_SINGLE) ? 8'h80 :
                   (sp == AMC_SPEED_DOUBLE) ? 8'h40 : 8'h20;
  endfunction

  function automatic logic [9:0] amc_mclk_base(input logic [1:0] sp);
    amc_mclk_base = (sp == AMC_SPEED_SINGLE) ? 10'h100 :
                    (sp == AMC_SPEED_DOUBLE) ? 10'h080 : 10'h040;
  endfunction

  function automatic logic [1:0] amc_speed_of_period(input logic [16:0] p);
    if (p < 17'(AMC_P_QS_MAX))
      amc_speed_of_period = AMC_SPEED_QUAD;
    else if (p < 17'(AMC_P_DS_MAX))
      amc_speed_of_period = AMC_SPEED_DOUBLE;
    else
      amc_speed_of_period = AMC_SPEED_SINGLE;
  endfunction

  function automatic logic amc_bit_legal(input logic [1:0] sp,
      input logic one_line, input logic [9:0] r);
    if (one_line)
      amc_bit_legal = (r == 10'h080);
    else
      amc_bit_legal = (r == 10'h020) || (r == 10'h030) || (r == 10'h040) ||
                      ((r == 10'h080) && (sp == AMC_SPEED_SINGLE));
  endfunction

  function automatic logic amc_mclk_legal(input logic [1:0] sp,
      input logic one_line, input logic [9:0] r);
    logic [9:0] b;
    b = amc_mclk_base(sp);
    if (one_line)
      amc_mclk_legal = (r == 10'h100);
    else
      amc_mclk_legal = (r == b) || (r == b + (b >> 1)) || (r == (b << 1));
  endfunction
endpackage
`default_nettype wire

// ---- include/amc_link_if.sv ----
/*
  Link between the clock selection device and the audio processor:
  master clocks, the four serial port clocks and the control port.
  Assumes both parties run on ref_clk; the shared serial clock wires are
  resolved here from each party's drive and active-low enable.
*/
`default_nettype none
interface amc_link_if;
  logic ext_master_clock_in;
  logic recovered_master_clock_out;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] dev_clk_o;
  logic [3:0] dev_clk_oe_n;
  logic [3:0] host_clk_o;
  logic [3:0] host_clk_oe_n;
  logic [3:0] port_clk;
  logic codec_port_frame_clock;
  logic codec_port_bit_clock;
  logic aux_port_frame_clock;
  logic aux_port_bit_clock;

  // An undriven serial clock reads low.
  assign port_clk = (~dev_clk_oe_n & dev_clk_o) |
                    (dev_clk_oe_n & ~host_clk_oe_n & host_clk_o);
  assign codec_port_frame_clock = port_clk[0];
  assign codec_port_bit_clock = port_clk[1];
  assign aux_port_frame_clock = port_clk[2];
  assign aux_port_bit_clock = port_clk[3];

  modport device (
    input ext_master_clock_in,
    output recovered_master_clock_out,
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    input reg_rd,
    output reg_rdata,
    output dev_clk_o,
    output dev_clk_oe_n,
    input port_clk
  );

  modport host (
    output ext_master_clock_in,
    input recovered_master_clock_out,
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input reg_rdata,
    output host_clk_o,
    output host_clk_oe_n,
    input port_clk
  );
endinterface
`default_nettype wire

// ---- core/amc_clock_switch.sv ----
/*
  Glitch-free two-way master clock switch.
  Assumes both candidate clocks are levels already in the ref_clk domain.
*/
`default_nettype none
module amc_clock_switch
  import amc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_a,
  input wire logic clk_b,
  input wire logic want_b,
  output logic clk_out,
  output logic using_b
);
  logic out_q;
  logic cur_q;
  logic cur_d;
  logic swap;

  // The choice moves only while both sources are low, so no phase is cut.
  assign swap = (want_b != cur_q) && !clk_a && !clk_b;
  assign cur_d = swap ? want_b : cur_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cur_q <= 1'b0;
    else
      cur_q <= cur_d;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      out_q <= 1'b0;
    else
      out_q <= cur_d ? clk_b : clk_a;
  end

  assign clk_out = out_q;
  assign using_b = cur_q;
endmodule
`default_nettype wire

// ---- core/amc_device.sv ----
/*
  Audio master clock selection device: reference tracking loop, recovered
  clock, source switching, master mode serial clocks and slave ratio check.
  Assumes all link clock pins are asynchronous to ref_clk and are synchronised.
*/
// The implementer's own choice: the plain strobed port.
`default_nettype none
// Operation
// - Master clock from loop or external input
// - Auto mode falls back to external glitch-free
// - Loop clock drives recovered clock output
// - Frame clock reference gives 256Fs output
// - Far side keeps external clock when unforced
// - Master timing from two selectable sources
// - Slave frame clock equals Fs, synchronous
// - Slave bit clock synchronous, 128/64/48/32 Fs
// - Slave bit ratios per speed, one-line 128
// - Slave master ratios per speed, one-line 256
// - One-line mode one only in slave
// - Speed class from sample rate ranges
// - Oversampling 128/64/32 by speed select
module amc_device
  import amc_pkg::*;
#(
  parameter int LOCK_TIMEOUT_CYC = AMC_LOCK_TIMEOUT_CYC
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  amc_link_if.device link,
  input wire logic rx_frame_sync,
  output logic int_master_clock,
  output logic ext_source_active,
  output logic pll_locked,
  output logic ratio_fault,
  output logic [7:0] oversample_ratio
);
  logic [7:0] clk_ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] rdata_q;
  logic [5:0] raw;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] prev_q;
  logic [5:0] rise;
  logic [16:0] per_cnt_q;
  logic [16:0] last_per_q;
  logic [16:0] diff;
  logic [2:0] hits_q;
  logic locked_q;
  logic ref_edge;
  logic timed_out;
  logic [16:0] acc_q;
  logic [16:0] acc_sum;
  logic recovered_master_clock_out_q;
  logic want_ext;
  logic sw_mclk;
  logic sw_ext;
  logic mclk_prev_q;
  logic mclk_edge;
  logic [9:0] base;
  logic [3:0] bdiv_q;
  logic [9:0] fdiv_q;
  logic m_sclk_q;
  logic m_lrck_q;
  logic [9:0] bcnt_q;
  logic [9:0] mcnt_q;
  logic fault_q;
  logic [7:0] os_q;
  logic [1:0] sel;
  logic [1:0] speed;
  logic one_line;
  logic force_lock;

  assign sel = clk_ctrl_q[AMC_CLK_SEL_LSB+:2];
  assign force_lock = clk_ctrl_q[AMC_CLK_FORCE_BIT];
  assign speed = mode_q[AMC_MODE_SPEED_LSB+:2];
  assign one_line = mode_q[AMC_MODE_ONE_LINE];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      clk_ctrl_q <= AMC_CLK_RST;
      mode_q <= AMC_MODE_RST;
    end
    else if (link.reg_wr)
    begin
      if (link.reg_addr == AMC_ADDR_CLK)
        clk_ctrl_q <= link.reg_wdata;
      if (link.reg_addr == AMC_ADDR_MODE)
        mode_q <= link.reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (link.reg_rd)
      unique case (link.reg_addr)
        AMC_ADDR_CLK: rdata_q <= clk_ctrl_q;
        AMC_ADDR_MODE: rdata_q <= mode_q;
        AMC_ADDR_STAT:
          rdata_q <= {3'h0, amc_speed_of_period(last_per_q), fault_q,
                      sw_ext, locked_q};
        default: rdata_q <= 8'h00;
      endcase
  end

  // Every link clock is brought into the ref_clk domain by two stages.
  assign raw = {rx_frame_sync, link.ext_master_clock_in, link.port_clk};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      prev_q <= 6'h00;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign rise = s2_q & ~prev_q;
  assign ref_edge = clk_ctrl_q[AMC_CLK_REF_BIT] ? rise[AMC_PIN_SAF] :
                    rise[AMC_SYNC_RX];
  assign timed_out = per_cnt_q >= 17'(LOCK_TIMEOUT_CYC);
  assign diff = (per_cnt_q > last_per_q) ? per_cnt_q - last_per_q :
                last_per_q - per_cnt_q;

  // The loop measures the reference period and counts stable periods.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      per_cnt_q <= 17'h0_0000;
      last_per_q <= 17'h1_FFFF;
      hits_q <= 3'h0;
    end
    else if (ref_edge)
    begin
      per_cnt_q <= 17'h0_0001;
      last_per_q <= per_cnt_q;
      if (diff > AMC_LOCK_TOL)
        hits_q <= 3'h0;
      else if (hits_q != AMC_LOCK_HITS)
        hits_q <= hits_q + 3'h1;
    end
    else if (timed_out)
      hits_q <= 3'h0;
    else
      per_cnt_q <= per_cnt_q + 17'h0_0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      locked_q <= 1'b0;
    else
      locked_q <= force_lock || (hits_q == AMC_LOCK_HITS && !timed_out);
  end

  // Toggling 512 times per measured period gives 256 clocks per frame.
  assign acc_sum = acc_q + AMC_PLL_STEP;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !locked_q)
    begin
      acc_q <= 17'h0_0000;
      recovered_master_clock_out_q <= 1'b0;
    end
    else if (acc_sum >= last_per_q)
    begin
      acc_q <= acc_sum - last_per_q;
      recovered_master_clock_out_q <= ~recovered_master_clock_out_q;
    end
    else
      acc_q <= acc_sum;
  end

  assign link.recovered_master_clock_out = recovered_master_clock_out_q;

  // Auto modes fall back to the external clock while the loop is unlocked.
  assign want_ext = (sel == AMC_SEL_EXT) ||
                    (sel[1] && !locked_q);

  amc_clock_switch u_switch (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_a(recovered_master_clock_out_q),
    .clk_b(s2_q[AMC_SYNC_EXT]),
    .want_b(want_ext),
    .clk_out(sw_mclk),
    .using_b(sw_ext)
  );

  // Master mode: 64Fs bit clock and Fs frame clock from the chosen clock.
  assign base = amc_mclk_base(speed);
  assign mclk_edge = sw_mclk != mclk_prev_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mclk_prev_q <= 1'b0;
      bdiv_q <= 4'h0;
      fdiv_q <= 10'h000;
      m_sclk_q <= 1'b0;
      m_lrck_q <= 1'b0;
    end
    else
    begin
      mclk_prev_q <= sw_mclk;
      if (mclk_edge)
      begin
        if (bdiv_q == 4'(base >> 6) - 4'h1)
        begin
          bdiv_q <= 4'h0;
          m_sclk_q <= ~m_sclk_q;
        end
        else
          bdiv_q <= bdiv_q + 4'h1;
        if (fdiv_q == base - 10'h001)
        begin
          fdiv_q <= 10'h000;
          m_lrck_q <= ~m_lrck_q;
        end
        else
          fdiv_q <= fdiv_q + 10'h001;
      end
    end
  end

  assign link.dev_clk_o = {m_sclk_q, m_lrck_q, m_sclk_q, m_lrck_q};
  assign link.dev_clk_oe_n = {{2{~mode_q[AMC_MODE_SAI_MASTER]}},
                              {2{~mode_q[AMC_MODE_CX_MASTER]}}};

  // Slave mode: each codec frame's bit and master clock counts are checked.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bcnt_q <= 10'h000;
      mcnt_q <= 10'h000;
      fault_q <= 1'b0;
    end
    else if (rise[AMC_PIN_CXF])
    begin
      bcnt_q <= {9'h000, rise[AMC_PIN_CXB]};
      mcnt_q <= {9'h000, mclk_edge & sw_mclk};
      fault_q <= !mode_q[AMC_MODE_CX_MASTER] &&
                 (!amc_bit_legal(speed, one_line, bcnt_q) ||
                  !amc_mclk_legal(speed, one_line, mcnt_q));
    end
    else
    begin
      if (rise[AMC_PIN_CXB] && bcnt_q != 10'h3FF)
        bcnt_q <= bcnt_q + 10'h001;
      if (mclk_edge && sw_mclk && mcnt_q != 10'h3FF)
        mcnt_q <= mcnt_q + 10'h001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      os_q <= 8'h80;
    else
      os_q <= amc_os_ratio(speed);
  end

  assign int_master_clock = sw_mclk;
  assign ext_source_active = sw_ext;
  assign pll_locked = locked_q;
  assign ratio_fault = fault_q;
  assign oversample_ratio = os_q;
  assign link.reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ---- core/amc_host.sv ----
/*
  Audio processor end: makes the external master clock, and in slave mode
  the serial port clocks, and passes software access to the device.
  Assumes software uses the plain register port on ref_clk.
*/
`default_nettype none
module amc_host
  import amc_pkg::*;
#(
  parameter int MCLK_HALF = AMC_HOST_MCLK_HALF
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  amc_link_if.host link,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  logic [7:0] ctrl_q;
  logic one_line_q;
  logic force_q;
  logic fwd;
  logic fwd_q;
  logic [7:0] own_q;
  logic [7:0] mdiv_q;
  logic mclk_q;
  logic mclk_on;
  logic [1:0] speed;
  logic [9:0] mr;
  logic [9:0] br;
  logic [9:0] base;
  logic legal;
  logic run;
  logic [10:0] acc_q;
  logic [10:0] acc_sum;
  logic [9:0] fcnt_q;
  logic sclk_q;
  logic lrck_q;

  assign fwd = addr < AMC_HOST_FWD_LIMIT;
  assign link.reg_addr = addr;
  assign link.reg_wdata = wdata;
  assign link.reg_wr = wr && fwd;
  assign link.reg_rd = rd && fwd;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= AMC_HOST_CTRL_RST;
      one_line_q <= 1'b0;
      force_q <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == AMC_HOST_ADDR_CTRL)
        ctrl_q <= wdata;
      if (addr == AMC_HOST_ADDR_CTRL2)
        one_line_q <= wdata[0];
      if (addr == AMC_ADDR_CLK)
        force_q <= wdata[AMC_CLK_FORCE_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fwd_q <= 1'b0;
      own_q <= 8'h00;
    end
    else
    begin
      fwd_q <= rd && fwd;
      if (addr == AMC_HOST_ADDR_CTRL)
        own_q <= ctrl_q;
      else if (addr == AMC_HOST_ADDR_CTRL2)
        own_q <= {6'h00, !legal, one_line_q};
      else
        own_q <= 8'h00;
    end
  end

  assign rdata = fwd_q ? link.reg_rdata : own_q;

  // The master clock runs while ctrl_q[0] is set or the device lock is not forced.
  assign mclk_on = ctrl_q[0] || !force_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mdiv_q <= 8'h00;
      mclk_q <= 1'b0;
    end
    else if (mdiv_q == 8'(MCLK_HALF - 1))
    begin
      mdiv_q <= 8'h00;
      mclk_q <= mclk_on ? ~mclk_q : 1'b0;
    end
    else
      mdiv_q <= mdiv_q + 8'h01;
  end

  assign link.ext_master_clock_in = mclk_q;

  assign speed = ctrl_q[3:2];
  assign base = amc_mclk_base(speed);
  assign mr = one_line_q ? 10'h100 :
              (ctrl_q[5:4] == 2'b00) ? base :
              (ctrl_q[5:4] == 2'b01) ? base + (base >> 1) : base << 1;
  assign br = one_line_q ? 10'h080 :
              (ctrl_q[7:6] == 2'b00) ? 10'h020 :
              (ctrl_q[7:6] == 2'b01) ? 10'h030 :
              (ctrl_q[7:6] == 2'b10) ? 10'h040 : 10'h080;
  assign legal = (speed != AMC_SPEED_RSVD) && (ctrl_q[5:4] != 2'b11) &&
                 amc_bit_legal(speed, one_line_q, br) &&
                 amc_mclk_legal(speed, one_line_q, mr);
  assign run = ctrl_q[1] && legal && mclk_on;

  // Clocks step on master clock edges only, so they stay synchronous.
  assign acc_sum = acc_q + {br, 1'b0};

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !run)
    begin
      acc_q <= 11'h000;
      fcnt_q <= 10'h000;
      sclk_q <= 1'b0;
      lrck_q <= 1'b0;
    end
    else if (mdiv_q == 8'(MCLK_HALF - 1))
    begin
      if (acc_sum >= {mr, 1'b0})
      begin
        acc_q <= acc_sum - {mr, 1'b0};
        sclk_q <= ~sclk_q;
      end
      else
        acc_q <= acc_sum;
      if (fcnt_q == mr - 10'h001)
      begin
        fcnt_q <= 10'h000;
        lrck_q <= ~lrck_q;
      end
      else
        fcnt_q <= fcnt_q + 10'h001;
    end
  end

  assign link.host_clk_o = {sclk_q, lrck_q, sclk_q, lrck_q};
  assign link.host_clk_oe_n = {4{~ctrl_q[1]}};
endmodule
`default_nettype wire

// ---- verification/amc_link_assertions.sv ----
/*
  Concurrent checks on the link between the clock selection device and
  the audio processor. Assumes one ref_clk domain and a bench that
  instantiates it beside the link interface.
*/
`default_nettype none
module amc_link_assertions
  import amc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_master_clock_in,
  input wire logic recovered_master_clock_out,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] dev_clk_oe_n,
  input wire logic ext_source_active,
  input wire logic pll_locked,
  input wire logic [7:0] oversample_ratio
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] clk_q;
  logic [7:0] mode_q;
  logic ext_q;
  logic [3:0] run_q;
  wire clk_wr = reg_wr && reg_addr == AMC_ADDR_CLK;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Shadow copies of the clock and mode registers as written.
  always_ff @(posedge ref_clk)
    if (sys_rst)
      clk_q <= AMC_CLK_RST;
    else if (clk_wr)
      clk_q <= reg_wdata;

  always_ff @(posedge ref_clk)
    if (sys_rst)
      mode_q <= AMC_MODE_RST;
    else if (reg_wr && reg_addr == AMC_ADDR_MODE)
      mode_q <= reg_wdata;

  // Cycles since the external master clock last changed, saturating.
  always_ff @(posedge ref_clk)
  begin
    ext_q <= ext_master_clock_in;
    if (sys_rst || ext_q != ext_master_clock_in)
      run_q <= 4'h0;
    else if (run_q != 4'hf)
      run_q <= run_q + 4'h1;
  end

  chk_clk_readback: assert property (reg_rd && reg_addr == AMC_ADDR_CLK
    |=> reg_rdata[3:0] == clk_q[3:0]) else $error("clock reg readback");
  chk_unmapped_read: assert property (reg_rd && reg_addr == 8'h05
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_force_lock: assert property (clk_wr && reg_wdata[3]
    |-> ##[1:2] pll_locked) else $error("force did not lock");
  chk_auto_fallback: assert property ($fell(pll_locked) && clk_q[1]
    |-> ##[1:40] ext_source_active) else $error("no fallback");
  chk_manual_ext: assert property (clk_wr && reg_wdata[1:0] == 2'h1
    |-> ##[1:40] ext_source_active) else $error("no manual switch");
  chk_quad_ratio: assert property (reg_wr && reg_addr == AMC_ADDR_MODE
    && reg_wdata[1:0] == 2'h2 |-> ##[1:3] oversample_ratio == 8'h20)
    else $error("quad oversampling");
  chk_slave_quiet: assert property (!mode_q[3] && !$past(mode_q[3])
    && !$past(mode_q[3], 2) |-> dev_clk_oe_n[1:0] == 2'h3)
    else $error("slave port driven");
  chk_master_drive: assert property (mode_q[3] && $past(mode_q[3])
    && $past(mode_q[3], 2) |-> dev_clk_oe_n[1:0] == 2'h0)
    else $error("master port idle");
  chk_ext_runs: assert property (!clk_q[3] && !$past(clk_q[3], 8)
    |-> run_q < 4'ha) else $error("external clock stopped");
  chk_recovered_master_clock_out_active: assert property (pll_locked && !clk_q[3]
    && !$past(clk_q[3]) |-> ##[0:8] $changed(recovered_master_clock_out))
    else $error("recovered clock idle");

  cover property ($rose(pll_locked));
  cover property ($rose(ext_source_active));
  cover property (mode_q[3] && dev_clk_oe_n[1:0] == 2'h0);
endmodule
`default_nettype wire

// ---- verification/tb_audio_master_clock_select.sv ----
/*
  Bench joining the device and processor ends over the link interface.
  Assumes the package, interface and both design ends are compiled first.
*/
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, a); \
    end \
  end
module tb_audio_master_clock_select
  import amc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LT = 2500;
  localparam int MH = 2;
  logic ref_clk, sys_rst, rx_frame_sync, sw_wr, sw_rd;
  logic [7:0] sw_addr, sw_wdata, sw_rdata, oversample_ratio;
  logic int_master_clock, ext_source_active, pll_locked, ratio_fault;
  int n_fail = 0, checks = 0, rper = 0, rcnt = 0;
  amc_link_if lnk();
  amc_device #(.LOCK_TIMEOUT_CYC(LT)) u_amc_device (.ref_clk, .sys_rst,
    .link(lnk), .rx_frame_sync, .int_master_clock, .ext_source_active,
    .pll_locked, .ratio_fault, .oversample_ratio);
  amc_host #(.MCLK_HALF(MH)) u_amc_host (.ref_clk, .sys_rst, .link(lnk),
    .addr(sw_addr), .wdata(sw_wdata), .wr(sw_wr), .rd(sw_rd),
    .rdata(sw_rdata));
  amc_link_assertions u_amc_link_assertions (.ref_clk, .sys_rst,
    .ext_master_clock_in(lnk.ext_master_clock_in),
    .recovered_master_clock_out(lnk.recovered_master_clock_out),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata),
    .dev_clk_oe_n(lnk.dev_clk_oe_n), .ext_source_active, .pll_locked,
    .oversample_ratio);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Receiver frame marker: a 4-cycle pulse every rper cycles, 0 = off.
  always @(posedge ref_clk)
  begin
    rcnt <= (rper == 0 || rcnt >= rper - 1) ? 0 : rcnt + 1;
    rx_frame_sync <= rper != 0 && rcnt < 4;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, m, e, input string n);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    `CHK(n, e, sw_rdata & m)
  endtask

  // One period of a reference (port clock index, or 4 for the receiver),
  // with codec bit clock and recovered clock rising edges inside it.
  task automatic meas(input int ix, output int per, nb, nr);
    logic p, b, r, s;
    per = 0;
    nb = 0;
    nr = 0;
    p = 1'b1;
    b = 1'b1;
    r = 1'b1;
    repeat (20000)
    begin
      @(posedge ref_clk);
      #1;
      s = ix < 4 ? lnk.port_clk[ix] : rx_frame_sync;
      if (s && !p && per > 0)
        break;
      if (s && !p)
        per = 1;
      else if (per > 0)
        per++;
      nb += int'(per > 0 && lnk.codec_port_bit_clock && !b);
      nr += int'(per > 0 && lnk.recovered_master_clock_out && !r);
      p = s;
      b = lnk.codec_port_bit_clock;
      r = lnk.recovered_master_clock_out;
    end
  endtask

  task automatic t_regs();
    rchk(AMC_ADDR_CLK, 8'hff, AMC_CLK_RST, "clk reset");
    rchk(AMC_ADDR_MODE, 8'hff, AMC_MODE_RST, "mode reset");
    rchk(AMC_ADDR_STAT, 8'h07, 8'h00, "status reset");
    rchk(8'h05, 8'hff, 8'h00, "unmapped");
    rchk(AMC_HOST_ADDR_CTRL, 8'hff, AMC_HOST_CTRL_RST, "host ctrl");
    wr(AMC_ADDR_CLK, 8'h06);
    rchk(AMC_ADDR_CLK, 8'hff, 8'h06, "clk rw");
    wr(AMC_ADDR_CLK, 8'h00);
  endtask

  task automatic t_os();
    for (int s = 0; s < 3; s++)
    begin
      wr(AMC_ADDR_MODE, 8'(s));
      cyc(3);
      `CHK("oversample", 8'h80 >> s, oversample_ratio)
    end
    wr(AMC_ADDR_MODE, 8'h00);
  endtask

  task automatic t_lock();
    int p, per, nb, nr;
    logic [1:0] sp;
    wr(AMC_ADDR_CLK, 8'h08);
    cyc(3);
    `CHK("forced lock", 1'h1, pll_locked)
    wr(AMC_ADDR_CLK, 8'h00);
    for (int i = 0; i < LT + 100 && pll_locked !== 1'b0; i++) cyc(1);
    for (int k = 0; k < 3; k++)
    begin
      p = k == 0 ? 600 : k == 1 ? 1200 : 2200;
      sp = p < AMC_P_QS_MAX ? 2'h2 : p < AMC_P_DS_MAX ? 2'h1 : 2'h0;
      rper = p;
      for (int i = 0; i < 8 * p && pll_locked !== 1'b1; i++) cyc(1);
      rchk(AMC_ADDR_STAT, 8'h19, {3'h0, sp, 3'h1}, "speed");
      meas(4, per, nb, nr);
      `CHK("recovered_master_clock_out edges", 1'h1, nr >= 255 && nr <= 257)
      rper = 0;
      for (int i = 0; i < LT + 100 && pll_locked !== 1'b0; i++) cyc(1);
      `CHK("unlock", 1'h0, pll_locked)
    end
  endtask

  task automatic t_auto();
    logic m;
    wr(AMC_ADDR_CLK, 8'h02);
    rper = 600;
    for (int i = 0; i < 4800 && pll_locked !== 1'b1; i++) cyc(1);
    cyc(50);
    `CHK("auto on loop", 1'h0, ext_source_active)
    rper = 0;
    for (int i = 0; i < LT + 200 && ext_source_active !== 1'b1; i++) cyc(1);
    rchk(AMC_ADDR_STAT, 8'h03, 8'h02, "fallback");
    rper = 600;
    for (int i = 0; i < 8000 && ext_source_active !== 1'b0; i++) cyc(1);
    `CHK("relock", 1'h0, ext_source_active)
    wr(AMC_ADDR_CLK, 8'h01);
    cyc(40);
    `CHK("manual ext", 1'h1, ext_source_active)
    // The external clock has a four-cycle period, so two cycles invert it.
    #1 m = int_master_clock;
    cyc(2);
    #1;
    `CHK("int mclk", ~m, int_master_clock)
    rper = 0;
  endtask

  task automatic t_master();
    int per, nb, nr;
    wr(AMC_HOST_ADDR_CTRL, 8'h01);
    for (int s = 0; s < 3; s++)
    begin
      wr(AMC_ADDR_MODE, 8'h08 | 8'(s));
      meas(0, per, nb, nr);
      meas(0, per, nb, nr);
      `CHK("frame", (256 >> s) * 2 * MH, per)
      `CHK("bits", 64, nb)
    end
    wr(AMC_ADDR_MODE, 8'h00);
  endtask

  task automatic t_slave();
    logic [6:0] sc [6] = '{7'h0b, 7'h15, 7'h13, 7'h28, 7'h43, 7'h42};
    logic [6:0] c;
    int brv, mrv;
    logic f, g;
    foreach (sc[k])
    begin
      c = sc[k];
      brv = c[1:0] == 2'h3 ? 128 : 32 + 16 * c[1:0];
      mrv = (256 >> c[5:4]) + (128 >> c[5:4]) * c[3:2];
      // Refused combos stop the processor's serial clocks, so the device keeps its
      // last verdict; code 42 has the processor framing plainly while the
      // device expects one-line framing, which the device must flag.
      f = c[6] && (brv != 128 || mrv != 256);
      g = !c[6] && brv == 128 && c[5:4] != 0;
      wr(AMC_HOST_ADDR_CTRL2, {7'h0, c[6] & c[0]});
      wr(AMC_HOST_ADDR_CTRL, {c[1:0], c[3:2], c[5:4], 2'h3});
      wr(AMC_ADDR_MODE, {5'h0, c[6], c[5:4]});
      cyc(6 * mrv * MH + 100);
      `CHK("ratio fault", f, ratio_fault)
      rchk(AMC_HOST_ADDR_CTRL2, 8'h02, {6'h0, g, 1'h0}, "combo");
    end
    wr(AMC_HOST_ADDR_CTRL2, 8'h00);
    wr(AMC_ADDR_MODE, 8'h00);
  endtask

  task automatic t_aux();
    int per, nb, nr;
    wr(AMC_HOST_ADDR_CTRL, 8'h03);
    wr(AMC_ADDR_CLK, 8'h04);
    for (int i = 0; i < 10000 && pll_locked !== 1'b1; i++) cyc(1);
    meas(2, per, nb, nr);
    `CHK("aux frame", 256 * 2 * MH, per)
    `CHK("recovered_master_clock_out 256fs", 1'h1, nr >= 255 && nr <= 257)
    wr(AMC_HOST_ADDR_CTRL, 8'h00);
  endtask

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_fail++;
    summarize();
  end

  initial
  begin
    sys_rst = 1'b1;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    cyc(10);
    sys_rst <= 1'b0;
    t_regs();
    t_os();
    t_lock();
    t_auto();
    t_master();
    t_slave();
    t_aux();
    summarize();
  end
endmodule
`default_nettype wire
